// ==== design/pel_logger.sv ====
// Purpose: event manager: active states, pop-ups, outputs, histories
// Assumes: cause and config inputs synchronous to clk_i
// Notes: one record written per cycle; pending edges queue per event
`timescale 1ns/1ps
module pel_logger #(
   parameter int NUM_EVT = 8,
   parameter int NUM_OUT = 4,
   parameter int BATT_EVT = 0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_EVT-1:0] cause_i,
   input wire logic battery_low_i,
   input wire logic [NUM_EVT*pel_pkg::FAM_W-1:0] cfg_family_i,
   input wire logic [NUM_EVT*pel_pkg::SEV_W-1:0] cfg_sev_i,
   input wire logic [NUM_EVT-1:0] cfg_latched_i,
   input wire logic [NUM_EVT-1:0] cfg_durational_i,
   input wire logic [NUM_EVT*NUM_OUT-1:0] cfg_out_map_i,
   input wire logic panel_reset_i,
   input wire logic remote_reset_i,
   input wire logic rd_req_i,
   input wire logic [pel_pkg::FAM_W-1:0] rd_family_i,
   input wire logic [pel_pkg::PTR_W-1:0] rd_index_i,
   output logic rd_valid_o,
   output logic rd_error_o,
   output logic [pel_pkg::REC_W-1:0] rd_data_o,
   output logic [pel_pkg::PTR_W-1:0] rd_count_o,
   output logic [NUM_EVT-1:0] active_o,
   output logic [NUM_EVT-1:0] active_hm_o,
   output logic popup_red_o,
   output logic popup_orange_o,
   output logic [NUM_OUT-1:0] dout_o,
   output logic [pel_pkg::TS_W-1:0] time_o,
   output logic log_busy_o
);
   localparam int FW = pel_pkg::FAM_W;
   localparam int SW = pel_pkg::SEV_W;
   localparam int PW = pel_pkg::PTR_W;
   localparam int AW = pel_pkg::ADDR_W;
   localparam logic [NUM_EVT-1:0] BATT_MASK = NUM_EVT'(1) << BATT_EVT;

   function automatic logic [PW-1:0] fam_depth(input logic [FW-1:0] f);
      fam_depth = PW'(pel_pkg::FAM_DEPTH[f]);
   endfunction

   function automatic logic [AW-1:0] fam_base(input logic [FW-1:0] f);
      fam_base = AW'(pel_pkg::FAM_BASE[f]);
   endfunction

   function automatic logic fam_ok(input logic [FW-1:0] f);
      fam_ok = (int'(f) < pel_pkg::NUM_FAM);
   endfunction

   logic [NUM_EVT-1:0] cause_eff;
   logic [NUM_EVT-1:0] prev_reg, prev_next;
   logic [NUM_EVT-1:0] act_reg, act_next;
   logic [NUM_EVT-1:0] pend_s_reg, pend_s_next;
   logic [NUM_EVT-1:0] pend_e_reg, pend_e_next;
   logic [NUM_EVT-1:0] hm_reg, hm_next;
   logic [NUM_OUT-1:0] dout_reg, dout_next;
   logic red_reg, red_next, orange_reg, orange_next;
   logic [pel_pkg::TS_W-1:0] ts_reg, ts_next;
   logic [PW-1:0] ptr_reg [pel_pkg::NUM_FAM];
   logic [PW-1:0] ptr_next [pel_pkg::NUM_FAM];
   logic [PW-1:0] cnt_reg [pel_pkg::NUM_FAM];
   logic [PW-1:0] cnt_next [pel_pkg::NUM_FAM];
   logic rdv_reg, rdv_next, rde_reg, rde_next;
   logic [PW-1:0] rdc_reg, rdc_next;
   logic clr_all;
   logic [NUM_EVT-1:0] rise, fall, gnt_s, gnt_e;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [pel_pkg::REC_W-1:0] wr_data;
   logic rd_en;
   logic [AW-1:0] rd_addr;

   // battery low feeds its own event slot
   assign cause_eff = cause_i | (battery_low_i ? BATT_MASK : '0);
   assign clr_all = panel_reset_i | remote_reset_i;

   // active state, pop-ups and output routing
   always_comb begin
      logic [SW-1:0] sv;
      sv = '0;
      prev_next = cause_eff;
      act_next = '0;
      hm_next = '0;
      dout_next = '0;
      red_next = 1'b0;
      orange_next = 1'b0;
      for (int i = 0; i < NUM_EVT; i++) begin
         if (cfg_latched_i[i]) begin
            // cause present wins over a clear in the same cycle
            act_next[i] = cause_eff[i] | (act_reg[i] & ~clr_all);
         end else begin
            act_next[i] = cause_eff[i];
         end
      end
      for (int i = 0; i < NUM_EVT; i++) begin
         sv = cfg_sev_i[i*SW +: SW];
         if (act_next[i] && sv == pel_pkg::SEV_HIGH) begin
            red_next = 1'b1;
            hm_next[i] = 1'b1;
         end
         if (act_next[i] && sv == pel_pkg::SEV_MED) begin
            orange_next = 1'b1;
            hm_next[i] = 1'b1;
         end
         for (int o = 0; o < NUM_OUT; o++) begin
            if (act_next[i] && cfg_out_map_i[i*NUM_OUT+o]) begin
               dout_next[o] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prev_reg <= '0;
         act_reg <= '0;
         hm_reg <= '0;
         dout_reg <= '0;
         red_reg <= 1'b0;
         orange_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         act_reg <= act_next;
         hm_reg <= hm_next;
         dout_reg <= dout_next;
         red_reg <= red_next;
         orange_reg <= orange_next;
      end
   end

   // edge capture and logging arbitration
   always_comb begin
      logic found;
      logic [FW-1:0] fam;
      logic [PW-1:0] code;
      logic [pel_pkg::PH_W-1:0] ph;
      found = 1'b0;
      fam = '0;
      code = '0;
      ph = pel_pkg::PH_INSTANT;
      rise = cause_eff & ~prev_reg;
      fall = ~cause_eff & prev_reg & cfg_durational_i;
      gnt_s = '0;
      gnt_e = '0;
      for (int i = 0; i < NUM_EVT; i++) begin
         if (!found && pend_s_reg[i]) begin
            found = 1'b1;
            gnt_s[i] = 1'b1;
            code = PW'(i);
            ph = cfg_durational_i[i] ? pel_pkg::PH_START
                                     : pel_pkg::PH_INSTANT;
         end
      end
      for (int i = 0; i < NUM_EVT; i++) begin
         if (!found && pend_e_reg[i]) begin
            found = 1'b1;
            gnt_e[i] = 1'b1;
            code = PW'(i);
            ph = pel_pkg::PH_END;
         end
      end
      // new edges win over the grant that retires the old one
      pend_s_next = (pend_s_reg & ~gnt_s) | rise;
      pend_e_next = (pend_e_reg & ~gnt_e) | fall;
      fam = cfg_family_i[code[$clog2(NUM_EVT)-1:0]*FW +: FW];
      ts_next = ts_reg + 32'h1;
      for (int f = 0; f < pel_pkg::NUM_FAM; f++) begin
         ptr_next[f] = ptr_reg[f];
         cnt_next[f] = cnt_reg[f];
      end
      // every severity is logged, low included
      wr_en = found & fam_ok(fam);
      wr_addr = fam_base(fam) + AW'(ptr_reg[fam]);
      wr_data = '0;
      wr_data[pel_pkg::REC_TS_LSB +: pel_pkg::TS_W] = ts_reg;
      wr_data[pel_pkg::REC_PH_LSB +: pel_pkg::PH_W] = ph;
      wr_data[pel_pkg::REC_LAT_BIT] =
         cfg_latched_i[code[$clog2(NUM_EVT)-1:0]];
      wr_data[pel_pkg::REC_SEV_LSB +: SW] =
         cfg_sev_i[code[$clog2(NUM_EVT)-1:0]*SW +: SW];
      wr_data[pel_pkg::REC_FAM_LSB +: FW] = fam;
      wr_data[pel_pkg::REC_CODE_LSB +: pel_pkg::CODE_W] =
         pel_pkg::CODE_W'(code);
      if (wr_en) begin
         // ring wraps onto the oldest entry of this family only
         if (ptr_reg[fam] == fam_depth(fam) - PW'(1)) begin
            ptr_next[fam] = '0;
         end else begin
            ptr_next[fam] = ptr_reg[fam] + PW'(1);
         end
         if (cnt_reg[fam] != fam_depth(fam)) begin
            cnt_next[fam] = cnt_reg[fam] + PW'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pend_s_reg <= '0;
         pend_e_reg <= '0;
         ts_reg <= pel_pkg::TS_RESET;
         for (int f = 0; f < pel_pkg::NUM_FAM; f++) begin
            ptr_reg[f] <= pel_pkg::PTR_RESET;
            cnt_reg[f] <= pel_pkg::PTR_RESET;
         end
      end else begin
         pend_s_reg <= pend_s_next;
         pend_e_reg <= pend_e_next;
         ts_reg <= ts_next;
         for (int f = 0; f < pel_pkg::NUM_FAM; f++) begin
            ptr_reg[f] <= ptr_next[f];
            cnt_reg[f] <= cnt_next[f];
         end
      end
   end

   // read port: index 0 is the oldest record of the family
   always_comb begin
      logic ok;
      logic [PW-1:0] oldest, pos, dep;
      logic [PW:0] sum;
      dep = '0;
      oldest = '0;
      pos = '0;
      sum = '0;
      ok = fam_ok(rd_family_i);
      rdc_next = rdc_reg;
      rd_addr = '0;
      if (ok) begin
         dep = fam_depth(rd_family_i);
         ok = rd_index_i < cnt_reg[rd_family_i];
         oldest = (cnt_reg[rd_family_i] == dep) ? ptr_reg[rd_family_i]
                                               : '0;
         sum = {1'b0, oldest} + {1'b0, rd_index_i};
         if (sum >= {1'b0, dep}) begin
            sum = sum - {1'b0, dep};
         end
         pos = sum[PW-1:0];
         rd_addr = fam_base(rd_family_i) + AW'(pos);
         if (rd_req_i) begin
            rdc_next = cnt_reg[rd_family_i];
         end
      end
      rd_en = rd_req_i & ok;
      rdv_next = rd_req_i & ok;
      rde_next = rd_req_i & ~ok;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdv_reg <= 1'b0;
         rde_reg <= 1'b0;
         rdc_reg <= '0;
      end else begin
         rdv_reg <= rdv_next;
         rde_reg <= rde_next;
         rdc_reg <= rdc_next;
      end
   end

   pel_mem #(
      .WIDTH(pel_pkg::REC_W),
      .DEPTH(pel_pkg::TOTAL_DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .wr_en_i(wr_en),
      .wr_addr_i(wr_addr),
      .wr_data_i(wr_data),
      .rd_en_i(rd_en),
      .rd_addr_i(rd_addr),
      .rd_data_o(rd_data_o)
   );

   assign rd_valid_o = rdv_reg;
   assign rd_error_o = rde_reg;
   assign rd_count_o = rdc_reg;
   assign active_o = act_reg;
   assign active_hm_o = hm_reg;
   assign popup_red_o = red_reg;
   assign popup_orange_o = orange_reg;
   assign dout_o = dout_reg;
   assign time_o = ts_reg;
   assign log_busy_o = |(pend_s_reg | pend_e_reg);
endmodule

// ==== design/pel_pkg.sv ====
// Purpose: shared constants for the protection event logger
// Assumes: one clock, synchronous active-low reset
// Notes: record layout and family history sizes live here
// What this block does
// - seven family histories sized 50,100,300,300,100,300,100 entries.
// - every record carries a timestamp; record store keeps contents.
// - severity high, medium or low; every event logged whatever severity.
// - full history overwrites its own oldest entry; others untouched.
// - duration events log start and end; instantaneous events log once.
// - latched event stays active after cause clears until user reset.
// - unlatched event active only while its cause is present.
// - latched reset accepted from panel button and from remote/PC.
// - a reset command clears all held latched events at once.
// - high severity gives red pop-up, medium gives orange pop-up.
// - each event maps to digital outputs singly or in groups.
// - active high and medium severity events are readable.
// - history read out oldest first; records carry sort keys.
// - every entry of every history is readable remotely.
// - low backup battery raises an alarm event.
package pel_pkg;
   localparam int NUM_FAM = 7;
   localparam int FAM_W = 3;
   localparam int SEV_W = 2;
   localparam int PH_W = 2;
   localparam int CODE_W = 8;
   localparam int TS_W = 32;
   localparam int PTR_W = 10;
   localparam int ADDR_W = 11;
   localparam int TOTAL_DEPTH = 1250;

   localparam int FAM_DEPTH [NUM_FAM] = '{50, 100, 300, 300, 100, 300, 100};
   localparam int FAM_BASE [NUM_FAM] = '{0, 50, 150, 450, 750, 850, 1150};

   localparam logic [FAM_W-1:0] FAM_TRIP = 3'h0;
   localparam logic [FAM_W-1:0] FAM_PROT = 3'h1;
   localparam logic [FAM_W-1:0] FAM_DIAG = 3'h2;
   localparam logic [FAM_W-1:0] FAM_METER = 3'h3;
   localparam logic [FAM_W-1:0] FAM_CONFIG = 3'h4;
   localparam logic [FAM_W-1:0] FAM_OPER = 3'h5;
   localparam logic [FAM_W-1:0] FAM_COMM = 3'h6;

   localparam logic [SEV_W-1:0] SEV_LOW = 2'h0;
   localparam logic [SEV_W-1:0] SEV_MED = 2'h1;
   localparam logic [SEV_W-1:0] SEV_HIGH = 2'h2;

   localparam logic [PH_W-1:0] PH_INSTANT = 2'h0;
   localparam logic [PH_W-1:0] PH_START = 2'h1;
   localparam logic [PH_W-1:0] PH_END = 2'h2;

   localparam int REC_TS_LSB = 0;
   localparam int REC_PH_LSB = 32;
   localparam int REC_LAT_BIT = 34;
   localparam int REC_SEV_LSB = 35;
   localparam int REC_FAM_LSB = 37;
   localparam int REC_CODE_LSB = 40;
   localparam int REC_W = 48;

   localparam logic [TS_W-1:0] TS_RESET = 32'h0;
   localparam logic [PTR_W-1:0] PTR_RESET = 10'h0;
endpackage

// ==== design/pel_mem.sv ====
// Purpose: record store for all family histories
// Assumes: one write port, one read port, same clock
// Notes: contents are never reset; stands in for retained storage
`timescale 1ns/1ps
module pel_mem #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 1250,
   parameter int AW = 11
) (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] store [DEPTH];

   // retained store, no reset on contents
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         store[wr_addr_i] <= wr_data_i;
      end
      if (rd_en_i) begin
         rd_data_o <= store[rd_addr_i];
      end
   end
endmodule

// ==== verif/pel_properties.sv ====
// Purpose: port-level checks of the event logger
// Assumes: sync active-low reset, one clock
// Notes: config inputs held steady while checked
`timescale 1ns/1ps
module pel_properties #(
   parameter int NUM_EVT = 8,
   parameter int BATT_EVT = 0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_EVT-1:0] cause_i,
   input wire logic battery_low_i,
   input wire logic [NUM_EVT*2-1:0] cfg_sev_i,
   input wire logic [NUM_EVT-1:0] cfg_latched_i,
   input wire logic panel_reset_i,
   input wire logic remote_reset_i,
   input wire logic rd_req_i,
   input wire logic [2:0] rd_family_i,
   input wire logic rd_valid_o,
   input wire logic rd_error_o,
   input wire logic [9:0] rd_count_o,
   input wire logic [NUM_EVT-1:0] active_o,
   input wire logic [NUM_EVT-1:0] active_hm_o,
   input wire logic popup_red_o,
   input wire logic popup_orange_o,
   input wire logic [31:0] time_o
);
   logic [NUM_EVT-1:0] eff, hi, med, lat;
   always_comb begin
      eff = cause_i;
      eff[BATT_EVT] = cause_i[BATT_EVT] | battery_low_i;
      lat = cfg_latched_i;
      for (int i = 0; i < NUM_EVT; i++) begin
         hi[i] = active_o[i] && cfg_sev_i[i*2+:2] == 2'h2;
         med[i] = active_o[i] && cfg_sev_i[i*2+:2] == 2'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_live;
      $past(rst_n_i);
   endsequence
   sequence s_req;
      rd_req_i;
   endsequence
   a_unlatched_follows: assert property (s_live |->
      (active_o & ~lat) == ($past(eff) & ~lat))
      else $error("unlatched active wrong");
   a_latched_holds: assert property (s_live ##0 (!$past(panel_reset_i)
      && !$past(remote_reset_i)) |-> (active_o & lat) ==
      (($past(eff) | $past(active_o)) & lat)) else $error("latch lost");
   a_panel_clears: assert property (s_live ##0 $past(panel_reset_i) |->
      (active_o & lat) == ($past(eff) & lat)) else $error("panel clear");
   a_remote_clears: assert property (s_live ##0 $past(remote_reset_i)
      |-> (active_o & lat) == ($past(eff) & lat)) else $error("remote clear");
   a_popup_colour: assert property (popup_red_o == |hi &&
      popup_orange_o == |med) else $error("popup colour wrong");
   a_hm_visible: assert property (active_hm_o == (hi | med))
      else $error("active high/medium wrong");
   a_read_answers: assert property (s_req |=> rd_valid_o ^ rd_error_o)
      else $error("read not answered");
   a_read_quiet: assert property (!rd_req_i |=> !rd_valid_o && !rd_error_o)
      else $error("spurious read answer");
   a_trip_depth: assert property (rd_req_i && rd_family_i == 3'h0 |=>
      rd_count_o <= 10'd50) else $error("trip count over depth");
   a_time_runs: assert property (s_live |-> time_o == $past(time_o) + 1)
      else $error("timestamp not running");
endmodule
bind pel_logger pel_properties #(.NUM_EVT(NUM_EVT), .BATT_EVT(BATT_EVT)) u_p (
   .clk_i, .rst_n_i, .cause_i, .battery_low_i, .cfg_sev_i, .cfg_latched_i,
   .panel_reset_i, .remote_reset_i, .rd_req_i, .rd_family_i, .rd_valid_o,
   .rd_error_o, .rd_count_o, .active_o, .active_hm_o, .popup_red_o,
   .popup_orange_o, .time_o);

// ==== verif/pel_reader.sv ====
// Purpose: remote reader model issuing history reads
// Assumes: one request per read, answer one cycle later
// Notes: released lines show inverted last value
`timescale 1ns/1ps
module pel_reader (
   input wire logic clk_i,
   input wire logic rd_valid_i,
   input wire logic rd_error_i,
   output logic rd_req_o,
   output logic [2:0] rd_family_o,
   output logic [9:0] rd_index_o
);
   initial begin
      rd_req_o = 1'b0;
      rd_family_o = 3'h0;
      rd_index_o = 10'h0;
   end
   task automatic do_read(input logic [2:0] f, input logic [9:0] i,
                          output logic ok, output logic err);
      @(negedge clk_i);
      rd_req_o = 1'b1;
      rd_family_o = f;
      rd_index_o = i;
      @(negedge clk_i);
      ok = rd_valid_i;
      err = rd_error_i;
      rd_req_o = 1'b0;
      rd_family_o = ~f;
      rd_index_o = ~i;
   endtask
endmodule

// ==== verif/protection_event_logger_test.sv ====
// Purpose: self-checking bench of the event logger
// Assumes: config fixed after reset
// Notes: random causes, then directed corner cases
`timescale 1ns/1ps
module protection_event_logger_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] cause_i = 8'h0;
   logic battery_low_i = 1'b0, panel_reset_i = 1'b0, remote_reset_i = 1'b0;
   logic [23:0] cfg_family_i;
   logic [15:0] cfg_sev_i;
   logic [7:0] cfg_latched_i = 8'h10, cfg_durational_i = 8'h04;
   logic [31:0] cfg_out_map_i, time_o, ts0;
   logic rd_req_i, rd_valid_o, rd_error_o, popup_red_o, popup_orange_o;
   logic log_busy_o, ok, err;
   logic [2:0] rd_family_i;
   logic [9:0] rd_index_i, rd_count_o, cnt, n0;
   logic [47:0] rd_data_o, rec;
   logic [7:0] active_o, active_hm_o;
   logic [3:0] dout_o;
   int errors = 0, samples_checked = 0, seed = 16;
   always #20 clk_i = ~clk_i;
   pel_logger #(.NUM_EVT(8), .NUM_OUT(4), .BATT_EVT(0)) DUT (.clk_i,
      .rst_n_i, .cause_i, .battery_low_i, .cfg_family_i, .cfg_sev_i,
      .cfg_latched_i, .cfg_durational_i, .cfg_out_map_i, .panel_reset_i,
      .remote_reset_i, .rd_req_i, .rd_family_i, .rd_index_i, .rd_valid_o,
      .rd_error_o, .rd_data_o, .rd_count_o, .active_o, .active_hm_o,
      .popup_red_o, .popup_orange_o, .dout_o, .time_o, .log_busy_o);
   pel_reader u_rd (.clk_i, .rd_valid_i(rd_valid_o), .rd_error_i(rd_error_o),
      .rd_req_o(rd_req_i), .rd_family_o(rd_family_i), .rd_index_o(rd_index_i));
   function automatic logic [2:0] fam_of(int i);
      return (i == 0) ? pel_pkg::FAM_DIAG : 3'(i - 1);
   endfunction
   function automatic logic [1:0] sev_of(int i);
      return (i == 0) ? pel_pkg::SEV_HIGH : 2'(i % 3);
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic rd(input logic [2:0] f, input int i);
      u_rd.do_read(f, 10'(i), ok, err);
      rec = rd_data_o;
      cnt = rd_count_o;
   endtask
   task automatic idle();
      for (int k = 0; k < 60 && log_busy_o !== 1'b0; k++) @(negedge clk_i);
      check(48'(log_busy_o), 48'h0);
   endtask
   task automatic hold(int e, int n);
      cause_i[e] = 1'b1;
      repeat (n) @(negedge clk_i);
      cause_i[e] = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   initial begin
      #(40 * 6000);
      errors++;
      results();
   end
   initial begin
      for (int i = 0; i < 8; i++) begin
         cfg_family_i[i*3+:3] = fam_of(i);
         cfg_sev_i[i*2+:2] = sev_of(i);
      end
      cfg_out_map_i = $random(seed);
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (300) begin
         @(negedge clk_i);
         cause_i = 8'($random(seed));
         panel_reset_i = ($random(seed) % 8 == 0);
         remote_reset_i = ($random(seed) % 8 == 1);
         battery_low_i = ($random(seed) % 16 == 0);
      end
      cause_i = 8'h0;
      battery_low_i = 1'b0;
      remote_reset_i = 1'b0;
      panel_reset_i = 1'b1;
      @(negedge clk_i);
      panel_reset_i = 1'b0;
      for (int j = 0; j < 2; j++) begin
         hold(4, 2);
         check(48'(active_o[4]), 48'h1);
         panel_reset_i = (j == 0);
         remote_reset_i = (j == 1);
         @(negedge clk_i);
         {panel_reset_i, remote_reset_i} = 2'h0;
         @(negedge clk_i);
         check(48'(active_o[4]), 48'h0);
      end
      for (int e = 1; e < 4; e++) begin
         cause_i[e] = 1'b1;
         repeat (2) @(negedge clk_i);
         check(48'({popup_red_o, popup_orange_o}), 48'({sev_of(e) == 2'h2,
            sev_of(e) == 2'h1}));
         check(48'(dout_o), 48'(cfg_out_map_i[e*4+:4]));
         cause_i[e] = 1'b0;
         repeat (2) @(negedge clk_i);
         check(48'(active_o[e]), 48'h0);
      end
      idle();
      rd(pel_pkg::FAM_PROT, 0);
      n0 = cnt;
      repeat (60) hold(1, 1);
      idle();
      rd(pel_pkg::FAM_TRIP, 0);
      ts0 = rec[31:0];
      check(48'(cnt), 48'd50);
      check(48'(rec[47:35]), 48'({8'h01, fam_of(1), sev_of(1)}));
      rd(pel_pkg::FAM_TRIP, 49);
      check(48'(rec[31:0] - ts0), 48'd147);
      rd(pel_pkg::FAM_PROT, 0);
      check(48'(cnt), 48'(n0));
      hold(2, 3);
      idle();
      rd(pel_pkg::FAM_PROT, 0);
      rd(pel_pkg::FAM_PROT, int'(cnt) - 1);
      check(48'(rec[33:32]), 48'(pel_pkg::PH_END));
      rd(pel_pkg::FAM_PROT, int'(cnt) - 2);
      check(48'(rec[33:32]), 48'(pel_pkg::PH_START));
      battery_low_i = 1'b1;
      repeat (2) @(negedge clk_i);
      check(48'(active_o[0]), 48'h1);
      battery_low_i = 1'b0;
      idle();
      rd(pel_pkg::FAM_DIAG, 0);
      rd(pel_pkg::FAM_DIAG, int'(cnt) - 1);
      check(48'(rec[47:40]), 48'h0);
      hold(3, 1);
      idle();
      rd(pel_pkg::FAM_DIAG, 0);
      rd(pel_pkg::FAM_DIAG, int'(cnt) - 1);
      check(48'(rec[47:35]), 48'({8'h03, pel_pkg::FAM_DIAG,
         pel_pkg::SEV_LOW}));
      rd(3'h7, 0);
      check(48'({err, ok}), 48'h2);
      rd(pel_pkg::FAM_TRIP, 50);
      check(48'({err, ok}), 48'h2);
      results();
   end
endmodule
